// >>> core/cnt_pkg.sv
/*
  shared constants and types for the counter block: register map, field
  positions, reset values, counter widths and counter family codes.
  assumes nothing of its surroundings.
*/
package cnt_pkg;

  localparam int RCA_W = 4;
  localparam int LA_W = 8;
  localparam int GRP_W = 10;
  localparam int RIP_W = 6;
  localparam int LOAD_W = 10;
  localparam int LFSR_W = 4;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_LOAD = 8'h08;
  localparam logic [7:0] ADDR_LFSR = 8'h0c;
  localparam logic [7:0] ADDR_RCA = 8'h10;
  localparam logic [7:0] ADDR_LA = 8'h14;
  localparam logic [7:0] ADDR_GRP = 8'h18;
  localparam logic [7:0] ADDR_RIP = 8'h1c;

  localparam int CTRL_EN_BIT = 0;
  localparam int CMD_LOAD_BIT = 1;
  localparam int CMD_CLR_BIT = 0;

  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic [LOAD_W-1:0] LOAD_RST = 10'h000;
  localparam logic [LFSR_W-1:0] LFSR_RST = 4'h0;

  typedef enum logic [3:0] {
    MODE_RIPPLE = 4'h1,
    MODE_CARRY = 4'h2,
    MODE_LOOK = 4'h4,
    MODE_GROUP = 4'h8
  } cnt_mode_e;

  typedef struct packed {
    logic clr;
    logic load;
    logic en;
  } cnt_ctrl_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } ahb_aph_s;

endpackage

// >>> core/lfsr4.sv
/*
  free-running 4-bit modified shift-register counter covering all sixteen codes.
  assumes a synchronous clear from the enclosing block.
*/
`timescale 1ns/10ps
module lfsr4
  import cnt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clr,
  output logic [LFSR_W-1:0] state
);

  logic [LFSR_W-1:0] state_ff;
  logic [LFSR_W-1:0] nxt_state;
  logic fb;

  // feedback term that also leaves and re-enters the all-zero code
  assign fb = (state_ff[0] & ~state_ff[3]) | (~state_ff[0] & state_ff[1] & state_ff[3]) |
              (~state_ff[0] & state_ff[2] & state_ff[3]) |
              (~state_ff[1] & ~state_ff[2] & ~state_ff[3]); // RULE2

  always_comb
  begin
    if (clr)
      nxt_state = LFSR_RST; // RULE14
    else
      nxt_state = {state_ff[2:0], fb}; // RULE1 RULE3
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_ff <= LFSR_RST;
    else
      state_ff <= nxt_state;
  end

  assign state = state_ff;

endmodule

// >>> core/bin_counter.sv
/*
  binary counter in one of four families: ripple, ripple-carry, lookahead-carry
  and the 10-bit grouped lookahead partition.
  assumes control pulses synchronous to hclk; the ripple family uses derived clocks.
*/
`timescale 1ns/10ps
module bin_counter
  import cnt_pkg::*;
#(
  parameter cnt_mode_e MODE = MODE_CARRY,
  parameter int WIDTH = RCA_W,
  parameter bit HAS_LOAD = 1'b1,
  parameter bit HAS_EN = 1'b1,
  parameter bit HAS_RST = 1'b1
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire cnt_ctrl_s ctrl,
  input wire logic [WIDTH-1:0] load_value,
  output logic [WIDTH-1:0] count
);

  logic en;
  logic ld;
  logic clr;

  // omitted controls collapse to constants
  assign en = HAS_EN ? ctrl.en : 1'b1; // RULE15
  assign ld = HAS_LOAD ? ctrl.load : 1'b0; // RULE15
  assign clr = HAS_RST ? ctrl.clr : 1'b0; // RULE15

  generate
    if (MODE == MODE_RIPPLE)
    begin : g_rip
      // free count only; stage k clocked by the fall of stage k-1
      for (genvar k = 0; k < WIDTH; k++)
      begin : g_stage
        logic bit_ff;
        if (k == 0)
        begin : g_first
          always_ff @(posedge hclk or negedge hresetn)
          begin
            if (!hresetn)
              bit_ff <= 1'b0;
            else
              bit_ff <= ~bit_ff; // RULE5 RULE6
          end
        end
        else
        begin : g_next
          always_ff @(negedge g_rip.g_stage[k-1].bit_ff or negedge hresetn)
          begin
            if (!hresetn)
              bit_ff <= 1'b0;
            else
              bit_ff <= ~bit_ff; // RULE5 RULE6
          end
        end
        assign count[k] = bit_ff;
      end
    end
    else
    begin : g_sync
      logic [WIDTH-1:0] count_ff;
      logic [WIDTH-1:0] nxt_count;
      logic [WIDTH-1:0] tog;
      if (MODE == MODE_CARRY)
      begin : g_rc
        logic [WIDTH-1:0] carry;
        assign carry[0] = en;
        for (genvar k = 1; k < WIDTH; k++)
        begin : g_c
          assign carry[k] = carry[k-1] & count_ff[k-1]; // RULE7 RULE8
        end
        assign tog = carry;
      end
      else if (MODE == MODE_LOOK)
      begin : g_la
        assign tog[0] = en;
        for (genvar k = 1; k < WIDTH; k++)
        begin : g_t
          assign tog[k] = en & (&count_ff[k-1:0]); // RULE11 RULE8
        end
      end
      else
      begin : g_grp
        logic low_group_carry;
        logic mid_group_term;
        logic mid_group_carry;
        logic high_group_carry;
        assign low_group_carry = count_ff[0] & count_ff[1] & count_ff[2] & en; // RULE12
        assign mid_group_term = count_ff[3] & count_ff[4] & count_ff[5]; // RULE12
        assign mid_group_carry = mid_group_term & count_ff[6]; // RULE12
        assign high_group_carry = mid_group_carry & count_ff[7] & count_ff[8]; // RULE12
        assign tog = {low_group_carry & high_group_carry,
                      low_group_carry & mid_group_carry & count_ff[7],
                      low_group_carry & mid_group_carry,
                      low_group_carry & mid_group_term,
                      low_group_carry & count_ff[3] & count_ff[4],
                      low_group_carry & count_ff[3],
                      low_group_carry,
                      en & count_ff[0] & count_ff[1],
                      en & count_ff[0],
                      en}; // RULE12
      end

      always_comb
      begin
        if (clr)
          nxt_count = '0; // RULE14
        else if (ld)
          nxt_count = load_value; // RULE10
        else
          nxt_count = count_ff ^ tog; // RULE4 RULE8
      end

      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          count_ff <= '0;
        else
          count_ff <= nxt_count;
      end

      assign count = count_ff;
    end
  endgenerate

endmodule

// >>> core/counter_block.sv
/*
  counter block top: an ahb-lite register slave steering a shift-register
  counter and four binary counters, with their counts readable on the bus.
  assumes a single ahb-lite master, word transfers only, and hclk at 10 MHz.
*/
// The AHB-Lite register port and the register addresses were chosen for this implementation.
// Summary of operation
// RULE1 - the 4-bit shift-register counter steps each clock through 0,1,3,7,f,e,d,a,5,b,6,c,9,2,4,8 and back to 0.
// RULE2 - its bit 0 takes (b0&~b3)|(~b0&b1&b3)|(~b0&b2&b3)|(~b1&~b2&~b3).
// RULE3 - its other bits each take the value of the next lower bit, as a plain shift chain.
// RULE4 - an n-bit binary counter walks all 2^n codes in weighted order and then wraps to zero.
// RULE5 - in the ripple counter each stage is clocked by the fall of the stage below, with no carries.
// RULE6 - the ripple counter only counts freely, with no load and no down count.
// RULE7 - the ripple-carry counter clocks every bit from hclk and passes a carry from stage to stage.
// RULE8 - bit 0 toggles with count enable, bit k when enable and all lower bits are high, else bits hold.
// RULE9 - the basic 4-bit ripple-carry counter counts modulo 16 under count enable and has a clearing reset.
// RULE10 - with the load strobe high each bit takes its load value regardless of enable.
// RULE11 - the lookahead counter toggles each stage on one wide term of all lower outputs.
// RULE12 - the 10-bit lookahead counter builds its toggles from the low, mid and high group terms.
// RULE13 - one 4-bit ripple-carry counter combines load, count enable and reset.
// RULE14 - reset clears every count synchronously, ahead of load and count, the shift counter included; the ripple counter here has no reset strobe.
// RULE15 - parameters pick each counter's family and width and drop unused controls.
`timescale 1ns/10ps
module counter_block
  import cnt_pkg::*;
#(
  parameter int CARRY_WIDTH = RCA_W,
  parameter int LOOK_WIDTH = LA_W,
  parameter int RIPPLE_WIDTH = RIP_W
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [LFSR_W-1:0] lfsr_count,
  output logic [CARRY_WIDTH-1:0] carry_count,
  output logic [LOOK_WIDTH-1:0] look_count,
  output logic [GRP_W-1:0] group_count,
  output logic [RIPPLE_WIDTH-1:0] ripple_count
);

  ahb_aph_s aph_ff;
  ahb_aph_s nxt_aph;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  logic en_ff;
  logic nxt_en;
  logic [LOAD_W-1:0] load_val_ff;
  logic [LOAD_W-1:0] nxt_load_val;
  logic load_pulse_ff;
  logic nxt_load_pulse;
  logic clr_pulse_ff;
  logic nxt_clr_pulse;
  logic live_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  logic [RIPPLE_WIDTH-1:0] rip_meta_ff;
  logic [RIPPLE_WIDTH-1:0] ripple_count_ff;
  logic [RIPPLE_WIDTH-1:0] ripple_raw;
  logic take;
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_load;
  cnt_ctrl_s ctrl;
  cnt_ctrl_s free_ctrl;

  // address phase accepted only for an active transfer while the bus is ready
  assign take = hsel & htrans[1] & hready;

  always_comb
  begin
    nxt_aph.valid = take;
    nxt_aph.write = hwrite;
    nxt_aph.addr = haddr[7:0];
  end

  // data phase writes
  assign wr_ctrl = aph_ff.valid & aph_ff.write & (aph_ff.addr == ADDR_CTRL);
  assign wr_cmd = aph_ff.valid & aph_ff.write & (aph_ff.addr == ADDR_CMD);
  assign wr_load = aph_ff.valid & aph_ff.write & (aph_ff.addr == ADDR_LOAD);

  always_comb
  begin
    nxt_en = wr_ctrl ? hwdata[CTRL_EN_BIT] : en_ff;
    nxt_load_val = wr_load ? hwdata[LOAD_W-1:0] : load_val_ff;
    // command bits are one-cycle strobes that never read back
    nxt_load_pulse = wr_cmd & hwdata[CMD_LOAD_BIT];
    nxt_clr_pulse = wr_cmd & hwdata[CMD_CLR_BIT];
  end

  // read data is prepared from the address phase so it stands in the data phase
  always_comb
  begin
    nxt_hrdata = 32'h0000_0000;
    if (take && !hwrite)
    begin
      case (haddr[7:0])
        ADDR_CTRL: nxt_hrdata[CTRL_EN_BIT] = en_ff;
        ADDR_LOAD: nxt_hrdata[LOAD_W-1:0] = load_val_ff;
        ADDR_LFSR: nxt_hrdata[LFSR_W-1:0] = lfsr_count;
        ADDR_RCA: nxt_hrdata[CARRY_WIDTH-1:0] = carry_count;
        ADDR_LA: nxt_hrdata[LOOK_WIDTH-1:0] = look_count;
        ADDR_GRP: nxt_hrdata[GRP_W-1:0] = group_count;
        ADDR_RIP: nxt_hrdata[RIPPLE_WIDTH-1:0] = ripple_count_ff;
        default: nxt_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      aph_ff <= '0;
      hrdata_ff <= 32'h0000_0000;
      en_ff <= CTRL_EN_RST;
      load_val_ff <= LOAD_RST;
      load_pulse_ff <= 1'b0;
      clr_pulse_ff <= 1'b0;
      live_ff <= 1'b0;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
    else
    begin
      aph_ff <= nxt_aph;
      hrdata_ff <= nxt_hrdata;
      en_ff <= nxt_en;
      load_val_ff <= nxt_load_val;
      load_pulse_ff <= nxt_load_pulse;
      clr_pulse_ff <= nxt_clr_pulse;
      // assertions wait one edge after reset release so $past never looks into reset
      live_ff <= 1'b1;
      // zero wait states and an okay response, still launched from flops
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  // ripple bits settle on derived clocks; two hclk flops bring them over
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rip_meta_ff <= '0;
      ripple_count_ff <= '0;
    end
    else
    begin
      rip_meta_ff <= ripple_raw;
      ripple_count_ff <= rip_meta_ff;
    end
  end

  assign ctrl = '{clr: clr_pulse_ff, load: load_pulse_ff, en: en_ff};
  assign free_ctrl = '{clr: 1'b0, load: 1'b0, en: 1'b1};

  lfsr4 u_lfsr
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .clr(clr_pulse_ff),
    .state(lfsr_count)
  );

  // load, enable and reset in one ripple-carry counter
  bin_counter #(
    .MODE(MODE_CARRY),
    .WIDTH(CARRY_WIDTH),
    .HAS_LOAD(1'b1),
    .HAS_EN(1'b1),
    .HAS_RST(1'b1)
  ) u_carry (
    .hclk(hclk),
    .hresetn(hresetn),
    .ctrl(ctrl),
    .load_value(load_val_ff[CARRY_WIDTH-1:0]),
    .count(carry_count)
  ); // RULE9 RULE13

  bin_counter #(
    .MODE(MODE_LOOK),
    .WIDTH(LOOK_WIDTH),
    .HAS_LOAD(1'b1),
    .HAS_EN(1'b1),
    .HAS_RST(1'b1)
  ) u_look (
    .hclk(hclk),
    .hresetn(hresetn),
    .ctrl(ctrl),
    .load_value(load_val_ff[LOOK_WIDTH-1:0]),
    .count(look_count)
  );

  // grouped partition built without a load path
  bin_counter #(
    .MODE(MODE_GROUP),
    .WIDTH(GRP_W),
    .HAS_LOAD(1'b0),
    .HAS_EN(1'b1),
    .HAS_RST(1'b1)
  ) u_group (
    .hclk(hclk),
    .hresetn(hresetn),
    .ctrl(ctrl),
    .load_value(load_val_ff),
    .count(group_count)
  ); // RULE15

  bin_counter #(
    .MODE(MODE_RIPPLE),
    .WIDTH(RIPPLE_WIDTH),
    .HAS_LOAD(1'b0),
    .HAS_EN(1'b0),
    .HAS_RST(1'b0)
  ) u_ripple (
    .hclk(hclk),
    .hresetn(hresetn),
    .ctrl(free_ctrl),
    .load_value('0),
    .count(ripple_raw)
  ); // RULE6

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign ripple_count = ripple_count_ff;

  function automatic logic [3:0] lfsr_succ(input logic [3:0] s);
    case (s)
      4'h0: lfsr_succ = 4'h1;
      4'h1: lfsr_succ = 4'h3;
      4'h3: lfsr_succ = 4'h7;
      4'h7: lfsr_succ = 4'hf;
      4'hf: lfsr_succ = 4'he;
      4'he: lfsr_succ = 4'hd;
      4'hd: lfsr_succ = 4'ha;
      4'ha: lfsr_succ = 4'h5;
      4'h5: lfsr_succ = 4'hb;
      4'hb: lfsr_succ = 4'h6;
      4'h6: lfsr_succ = 4'hc;
      4'hc: lfsr_succ = 4'h9;
      4'h9: lfsr_succ = 4'h2;
      4'h2: lfsr_succ = 4'h4;
      4'h4: lfsr_succ = 4'h8;
      default: lfsr_succ = 4'h0;
    endcase
  endfunction

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn || !live_ff);

  property p_lfsr_seq;
    !clr_pulse_ff |=> lfsr_count == lfsr_succ($past(lfsr_count));
  endproperty
  a_lfsr_seq: assert property (p_lfsr_seq) else $error("shift counter left its code sequence"); // RULE1

  property p_lfsr_fb;
    !clr_pulse_ff |=> lfsr_count[0] == (($past(lfsr_count[0]) & ~$past(lfsr_count[3])) |
      (~$past(lfsr_count[0]) & $past(lfsr_count[1]) & $past(lfsr_count[3])) |
      (~$past(lfsr_count[0]) & $past(lfsr_count[2]) & $past(lfsr_count[3])) |
      (~$past(lfsr_count[1]) & ~$past(lfsr_count[2]) & ~$past(lfsr_count[3])));
  endproperty
  a_lfsr_fb: assert property (p_lfsr_fb) else $error("shift counter feedback bit wrong"); // RULE2

  property p_lfsr_shift;
    !clr_pulse_ff |=> lfsr_count[3:1] == $past(lfsr_count[2:0]);
  endproperty
  a_lfsr_shift: assert property (p_lfsr_shift) else $error("shift counter chain broken"); // RULE3

  property p_carry_inc;
    en_ff && !load_pulse_ff && !clr_pulse_ff |=> carry_count == $past(carry_count) + 4'h1;
  endproperty
  a_carry_inc: assert property (p_carry_inc) else $error("ripple-carry counter did not step by one"); // RULE4

  property p_carry_hold;
    !en_ff && !load_pulse_ff && !clr_pulse_ff |=> $stable(carry_count) && $stable(look_count);
  endproperty
  a_carry_hold: assert property (p_carry_hold) else $error("counter moved without enable"); // RULE8

  property p_carry_wrap;
    en_ff && !load_pulse_ff && !clr_pulse_ff && carry_count == 4'hf |=> carry_count == 4'h0;
  endproperty
  a_carry_wrap: assert property (p_carry_wrap) else $error("ripple-carry counter did not wrap at 16"); // RULE9

  property p_load;
    load_pulse_ff && !clr_pulse_ff |=>
      carry_count == $past(load_val_ff[3:0]) && look_count == $past(load_val_ff[7:0]);
  endproperty
  a_load: assert property (p_load) else $error("load value not taken"); // RULE10

  property p_look_inc;
    en_ff && !load_pulse_ff && !clr_pulse_ff |=> look_count == $past(look_count) + 8'h01;
  endproperty
  a_look_inc: assert property (p_look_inc) else $error("lookahead counter did not step by one"); // RULE11

  property p_group_top;
    en_ff && !clr_pulse_ff && group_count[8:0] == 9'h1ff |=> group_count == {~$past(group_count[9]), 9'h000};
  endproperty
  a_group_top: assert property (p_group_top) else $error("grouped counter top bit missed its carry"); // RULE12

  property p_group_load_ignored;
    load_pulse_ff && !en_ff && !clr_pulse_ff |=> $stable(group_count);
  endproperty
  a_group_load_ignored: assert property (p_group_load_ignored) else $error("grouped counter took a load"); // RULE15

  property p_clear;
    clr_pulse_ff |=> lfsr_count == 4'h0 && carry_count == 4'h0 && look_count == 8'h00 && group_count == 10'h000;
  endproperty
  a_clear: assert property (p_clear) else $error("reset strobe did not clear the counts"); // RULE14

  property p_ripple_step;
    ripple_count_ff != 6'h00 |=> ripple_count_ff == $past(ripple_count_ff) + 6'h01;
  endproperty
  a_ripple_step: assert property (p_ripple_step) else $error("ripple counter did not count freely"); // RULE5

  property p_group_inc;
    en_ff && !clr_pulse_ff |=> group_count == $past(group_count) + 10'h001;
  endproperty
  a_group_inc: assert property (p_group_inc) else $error("grouped counter did not step by one"); // RULE12

  property p_group_hold;
    !en_ff && !clr_pulse_ff |=> $stable(group_count);
  endproperty
  a_group_hold: assert property (p_group_hold) else $error("grouped counter moved without enable"); // RULE8

  property p_look_wrap;
    en_ff && !load_pulse_ff && !clr_pulse_ff && look_count == 8'hff |=> look_count == 8'h00;
  endproperty
  a_look_wrap: assert property (p_look_wrap) else $error("lookahead counter did not wrap to zero"); // RULE4

  property p_clear_beats_load;
    clr_pulse_ff && load_pulse_ff |=> carry_count == 4'h0 && look_count == 8'h00;
  endproperty
  a_clear_beats_load: assert property (p_clear_beats_load) else $error("load won over the reset strobe"); // RULE14

  c_lfsr_last: cover property (lfsr_count == 4'h8 ##1 lfsr_count == 4'h0);
  c_carry_wrap: cover property (carry_count == 4'hf ##1 carry_count == 4'h0);
  c_group_top: cover property ($rose(group_count[9]));
  c_load: cover property (load_pulse_ff && en_ff);

endmodule

// >>> test/tb_counter_block.sv
/*
  self-checking bench for counter_block: drives the ahb-lite register port,
  walks the shift counter, the binary counters and the ripple counter.
  assumes the hand-over timing: zero wait states, strobes land one edge after
  the write data edge, enable takes effect one edge after the data edge too.
*/
`timescale 1ns/10ps
module tb_counter_block
  import cnt_pkg::*;
;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [LFSR_W-1:0] lfsr_count;
  logic [RCA_W-1:0] carry_count;
  logic [LA_W-1:0] look_count;
  logic [GRP_W-1:0] group_count;
  logic [RIP_W-1:0] ripple_count;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [3:0] lfsr_seq [16] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf, 4'he, 4'hd, 4'ha,
                                4'h5, 4'hb, 4'h6, 4'hc, 4'h9, 4'h2, 4'h4, 4'h8};

  counter_block u_counter_block (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lfsr_count(lfsr_count),
    .carry_count(carry_count), .look_count(look_count), .group_count(group_count),
    .ripple_count(ripple_count)
  );

  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  task automatic give_verdict();
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // cut a hang short
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles >= 5000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_count(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // address phase, then data phase; returns at the edge that ends the data phase
  task automatic ahb_cycle(input logic [7:0] addr, input logic wr, input logic [31:0] wdata,
                           output logic [31:0] rdata);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, addr};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wdata;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdata = hrdata;
    check_word({31'h0, hresp}, 32'h0);
  endtask

  task automatic ahb_write(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] dummy;
    ahb_cycle(addr, 1'b1, data, dummy);
  endtask

  task automatic read_check(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    ahb_cycle(addr, 1'b0, 32'h0, got);
    check_word(got, exp);
  endtask

  task automatic test_reset();
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    check_count({6'h0, lfsr_count}, 10'h000);
    check_count({6'h0, carry_count}, 10'h000);
    check_count({2'h0, look_count}, 10'h000);
    check_count(group_count, 10'h000);
    check_word({31'h0, hreadyout}, 32'h1);
    tick(1);
    check_count({6'h0, lfsr_count}, 10'h001);
  endtask

  // count from zero through every group carry, then stop
  task automatic test_count_wrap();
    ahb_write(ADDR_CMD, 32'h1);
    tick(2);
    check_count(group_count, 10'h000);
    ahb_write(ADDR_CTRL, 32'h1);
    for (int i = 1; i <= 1030; i++)
    begin
      tick(1);
      check_count({6'h0, carry_count}, 10'(i % 16));
      check_count({2'h0, look_count}, 10'(i % 256));
      check_count(group_count, 10'(i % 1024));
    end
    ahb_write(ADDR_CTRL, 32'h0);
    tick(4);
    check_count({6'h0, carry_count}, 10'h009);
    check_count({2'h0, look_count}, 10'h009);
    check_count(group_count, 10'h009);
  endtask

  task automatic test_load_regs();
    ahb_write(ADDR_LOAD, 32'h2a5);
    read_check(ADDR_LOAD, 32'h2a5);
    ahb_write(ADDR_CMD, 32'h2);
    tick(2);
    check_count({6'h0, carry_count}, 10'h005);
    check_count({2'h0, look_count}, 10'h0a5);
    check_count(group_count, 10'h009);
    read_check(ADDR_RCA, 32'h5);
    read_check(ADDR_LA, 32'ha5);
    read_check(ADDR_GRP, 32'h9);
    read_check(ADDR_CMD, 32'h0);
    read_check(ADDR_CTRL, 32'h0);
    read_check(8'h20, 32'h0);
  endtask

  // load wins over enable, then the counts wrap to zero
  task automatic test_load_enabled();
    ahb_write(ADDR_CTRL, 32'h1);
    ahb_write(ADDR_LOAD, 32'h3ff);
    ahb_write(ADDR_CMD, 32'h2);
    tick(1);
    check_count({6'h0, carry_count}, 10'h00f);
    check_count({2'h0, look_count}, 10'h0ff);
    tick(1);
    check_count({6'h0, carry_count}, 10'h000);
    check_count({2'h0, look_count}, 10'h000);
  endtask

  // clear beats load; shift counter restarts, ripple counter is untouched
  task automatic test_clear_wins();
    logic [5:0] r0;
    ahb_write(ADDR_CMD, 32'h3);
    tick(1);
    r0 = ripple_count;
    check_count({6'h0, lfsr_count}, 10'h000);
    check_count({6'h0, carry_count}, 10'h000);
    check_count({2'h0, look_count}, 10'h000);
    check_count(group_count, 10'h000);
    for (int i = 1; i <= 17; i++)
    begin
      tick(1);
      check_count({6'h0, lfsr_count}, {6'h0, lfsr_seq[i % 16]});
      check_count({6'h0, carry_count}, 10'(i % 16));
      check_count({4'h0, ripple_count}, {4'h0, 6'(r0 + 6'(i))});
    end
    read_check(ADDR_CTRL, 32'h1);
  endtask

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    test_reset();
    test_count_wrap();
    test_load_regs();
    test_load_enabled();
    test_clear_wins();
    give_verdict();
  end
endmodule
